/* mcs_pkg.sv */
// constants, register layout and state type of the mcu clock system
package mcs_pkg;

  // register indices; byte address is four times the index
  localparam logic [7:0] MCS_IDX_MAIN    = 8'h14;
  localparam logic [7:0] MCS_IDX_PERIPH  = 8'h15;
  localparam logic [7:0] MCS_IDX_STATUS  = 8'h16;

  localparam logic [7:0] MCS_MAIN_RST    = 8'h00;
  localparam logic [7:0] MCS_PERIPH_RST  = 8'h00;
  localparam logic [7:0] MCS_MAIN_MASK   = 8'hEF;
  localparam logic [7:0] MCS_PERIPH_MASK = 8'h4F;

  // main_clock_control fields
  localparam int MCS_SRC_SEL_BIT   = 0;
  localparam int MCS_PRESCALE_BIT  = 1;
  localparam int MCS_CPU_SPEED_BIT = 2;
  localparam int MCS_HALVING_BIT   = 3;
  localparam int MCS_TMR_SEL_BIT   = 5;
  localparam int MCS_OSC_LO_BIT    = 6;
  localparam int MCS_OSC_HI_BIT    = 7;
  // peripheral_clock_register fields
  localparam int MCS_PUMP_RATE_BIT = 0;
  localparam int MCS_BEEP_SEL_BIT  = 1;
  localparam int MCS_CHOP_LO_BIT   = 2;
  localparam int MCS_CHOP_HI_BIT   = 3;
  localparam int MCS_PUMP_EN_BIT   = 6;

  // divider periods counted in half periods of their source clock
  localparam int MCS_CW = 12;
  localparam logic [11:0] MCS_P_CPU_00  = 12'h00D; // 6.5
  localparam logic [11:0] MCS_P_CPU_01  = 12'h019; // 12.5
  localparam logic [11:0] MCS_P_CPU_10  = 12'h004; // 2
  localparam logic [11:0] MCS_P_CPU_11  = 12'h008; // 4
  localparam logic [11:0] MCS_P_ADC_0   = 12'h032; // 25
  localparam logic [11:0] MCS_P_ADC_1   = 12'h064; // 50
  localparam logic [11:0] MCS_P_BEEP_0  = 12'h1F4; // 250
  localparam logic [11:0] MCS_P_BEEP_1  = 12'h2EE; // 375
  localparam logic [11:0] MCS_P_EXT_8   = 12'h010; // 8
  localparam logic [11:0] MCS_P_PUMP_0  = 12'h190; // 200
  localparam logic [11:0] MCS_P_PUMP_1  = 12'h0C8; // 100
  localparam logic [11:0] MCS_P_EXT_32  = 12'h040; // 32
  localparam logic [11:0] MCS_P_CLK_500 = 12'h3E8; // 500
  localparam logic [11:0] MCS_P_CLK_1K  = 12'h7D0; // 1000

  localparam int MCS_NCH = 6;
  localparam int CH_CPU = 0, CH_ADC = 1, CH_BEEP = 2;
  localparam int CH_PUMP = 3, CH_CHOP = 4, CH_TMR = 5;

  typedef enum logic [1:0] {SRC_MAIN, SRC_SEC, SRC_EXT} mcs_src_t;

  typedef struct packed {
    logic                   ick_s1;
    logic                   ick_s2;
    logic                   ick_d;
    logic                   eck_s1;
    logic                   eck_s2;
    logic                   eck_d;
    logic [7:0]             main_reg;
    logic [7:0]             periph_reg;
    logic                   wr_pend;
    logic [7:0]             wr_idx;
    logic [31:0]            rdata;
    logic                   ready;
    logic                   int_en;
    logic                   ext_en;
    logic                   main_clk;
    logic                   sec_clk;
    logic [1:0]             sec_cnt;
    logic [5:0][11:0]       cnt;
    logic [5:0][13:0]       key;
    logic [5:0]             clk_out;
  } mcs_state_t;

endpackage

/* mcs_clock_system.sv */
// clock selection, dividers and register slave of the mcu clock system
//
// The implementer's own choice: the AHB-Lite slave port.
`timescale 1ns/1ps
module mcs_clock_system (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        internal_osc_clock,
  input  wire logic        external_osc_clock,
  input  wire logic        sleep_req,
  output logic             int_osc_en,
  output logic             ext_osc_en,
  output logic             main_clock,
  output logic             secondary_clock,
  output logic             cpu_cycle_clk,
  output logic             converter_sample_rate,
  output logic             beeper_clk,
  output logic             pump_clk,
  output logic             chopper_ctrl,
  output logic             timer_display_clock
);

  ////////////////////////////////////////////////////////////////////////////
  // state

  mcs_pkg::mcs_state_t st_reg;
  mcs_pkg::mcs_state_t st_next;

  logic                  source_select_bit;
  logic                  prescale_bit;
  logic                  cpu_speed_bit;
  logic                  halving_bit;
  logic                  timer_clock_select_bit;
  logic [1:0]            osc_ctrl;
  logic                  pump_rate_bit;
  logic                  beep_sel_bit;
  logic [1:0]            chopper_select_field;
  logic                  pump_enable_bit;
  logic                  ick_edge;
  logic                  eck_edge;
  logic                  main_ht;
  logic                  sec_ht;
  logic [5:0][11:0]      per;
  mcs_pkg::mcs_src_t     src [mcs_pkg::MCS_NCH];

  assign source_select_bit      = st_reg.main_reg[mcs_pkg::MCS_SRC_SEL_BIT];
  assign prescale_bit           = st_reg.main_reg[mcs_pkg::MCS_PRESCALE_BIT];
  assign cpu_speed_bit          = st_reg.main_reg[mcs_pkg::MCS_CPU_SPEED_BIT];
  assign halving_bit            = st_reg.main_reg[mcs_pkg::MCS_HALVING_BIT];
  assign timer_clock_select_bit = st_reg.main_reg[mcs_pkg::MCS_TMR_SEL_BIT];
  assign osc_ctrl = {st_reg.main_reg[mcs_pkg::MCS_OSC_HI_BIT],
                     st_reg.main_reg[mcs_pkg::MCS_OSC_LO_BIT]};
  assign pump_rate_bit   = st_reg.periph_reg[mcs_pkg::MCS_PUMP_RATE_BIT];
  assign beep_sel_bit    = st_reg.periph_reg[mcs_pkg::MCS_BEEP_SEL_BIT];
  assign chopper_select_field = {st_reg.periph_reg[mcs_pkg::MCS_CHOP_HI_BIT],
                                 st_reg.periph_reg[mcs_pkg::MCS_CHOP_LO_BIT]};
  assign pump_enable_bit = st_reg.periph_reg[mcs_pkg::MCS_PUMP_EN_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // source ticks: each oscillator edge is one half period of that source

  // a stopped oscillator may float, so its edges are ignored while disabled
  assign ick_edge = (st_reg.ick_s2 ^ st_reg.ick_d) & st_reg.int_en;
  assign eck_edge = (st_reg.eck_s2 ^ st_reg.eck_d) & st_reg.ext_en;

  always_comb begin
    if (!source_select_bit) begin
      main_ht = ick_edge;
    end else if (halving_bit) begin
      main_ht = eck_edge & st_reg.eck_s2;
    end else begin
      main_ht = eck_edge;
    end
  end

  assign sec_ht = prescale_bit ? (main_ht & (st_reg.sec_cnt == 2'd3))
                               : main_ht;

  ////////////////////////////////////////////////////////////////////////////
  // per-channel source and period selection

  always_comb begin
    src[mcs_pkg::CH_CPU] = mcs_pkg::SRC_MAIN;
    case ({cpu_speed_bit, prescale_bit})
      2'b00:   per[mcs_pkg::CH_CPU] = mcs_pkg::MCS_P_CPU_00;
      2'b01:   per[mcs_pkg::CH_CPU] = mcs_pkg::MCS_P_CPU_01;
      2'b10:   per[mcs_pkg::CH_CPU] = mcs_pkg::MCS_P_CPU_10;
      default: per[mcs_pkg::CH_CPU] = mcs_pkg::MCS_P_CPU_11;
    endcase
    src[mcs_pkg::CH_ADC] = mcs_pkg::SRC_MAIN;
    per[mcs_pkg::CH_ADC] = prescale_bit ? mcs_pkg::MCS_P_ADC_1
                                        : mcs_pkg::MCS_P_ADC_0;
    if (!beep_sel_bit) begin
      src[mcs_pkg::CH_BEEP] = mcs_pkg::SRC_SEC;
      per[mcs_pkg::CH_BEEP] = mcs_pkg::MCS_P_BEEP_0;
    end else if (!source_select_bit) begin
      src[mcs_pkg::CH_BEEP] = mcs_pkg::SRC_SEC;
      per[mcs_pkg::CH_BEEP] = mcs_pkg::MCS_P_BEEP_1;
    end else begin
      src[mcs_pkg::CH_BEEP] = mcs_pkg::SRC_EXT;
      per[mcs_pkg::CH_BEEP] = mcs_pkg::MCS_P_EXT_8;
    end
    if (source_select_bit) begin
      src[mcs_pkg::CH_PUMP] = mcs_pkg::SRC_EXT;
      per[mcs_pkg::CH_PUMP] = mcs_pkg::MCS_P_EXT_32;
    end else begin
      src[mcs_pkg::CH_PUMP] = mcs_pkg::SRC_MAIN;
      per[mcs_pkg::CH_PUMP] = pump_rate_bit ? mcs_pkg::MCS_P_PUMP_1
                                            : mcs_pkg::MCS_P_PUMP_0;
    end
    src[mcs_pkg::CH_CHOP] = mcs_pkg::SRC_SEC;
    per[mcs_pkg::CH_CHOP] = chopper_select_field[0] ? mcs_pkg::MCS_P_CLK_1K
                                                    : mcs_pkg::MCS_P_CLK_500;
    if (timer_clock_select_bit) begin
      src[mcs_pkg::CH_TMR] = mcs_pkg::SRC_EXT;
      per[mcs_pkg::CH_TMR] = mcs_pkg::MCS_P_EXT_32;
    end else begin
      src[mcs_pkg::CH_TMR] = mcs_pkg::SRC_SEC;
      per[mcs_pkg::CH_TMR] = mcs_pkg::MCS_P_CLK_1K;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    logic        tick;
    logic [13:0] key;
    logic [5:0]  div_out;
    logic [31:0] rd;
    tick    = 1'b0;
    key     = '0;
    div_out = '0;
    rd      = '0;
    st_next = st_reg;

    st_next.ick_s1 = internal_osc_clock;
    st_next.ick_s2 = st_reg.ick_s1;
    st_next.ick_d  = st_reg.ick_s2;
    st_next.eck_s1 = external_osc_clock;
    st_next.eck_s2 = st_reg.eck_s1;
    st_next.eck_d  = st_reg.eck_s2;

    if (sleep_req) begin
      st_next.int_en = 1'b0;
      st_next.ext_en = 1'b0;
    end else begin
      case (osc_ctrl)
        2'b00:   {st_next.int_en, st_next.ext_en} = 2'b11;
        2'b10:   {st_next.int_en, st_next.ext_en} = 2'b01;
        default: {st_next.int_en, st_next.ext_en} = 2'b10;
      endcase
    end

    if (main_ht) begin
      st_next.sec_cnt  = st_reg.sec_cnt + 2'd1;
      st_next.main_clk = ~st_reg.main_clk;
    end
    if (sec_ht) begin
      st_next.sec_clk = ~st_reg.sec_clk;
    end

    // a changed selection restarts the divider at count zero, so its output restarts high
    for (int i = 0; i < mcs_pkg::MCS_NCH; i++) begin
      case (src[i])
        mcs_pkg::SRC_MAIN: tick = main_ht;
        mcs_pkg::SRC_SEC:  tick = sec_ht;
        default:           tick = eck_edge;
      endcase
      key = {src[i], per[i]};
      if (key != st_reg.key[i]) begin
        st_next.key[i] = key;
        st_next.cnt[i] = '0;
      end else if (tick) begin
        st_next.cnt[i] = (st_reg.cnt[i] == per[i] - 12'd1) ? '0
                         : st_reg.cnt[i] + 12'd1;
      end
      div_out[i] = st_next.cnt[i] < ((per[i] + 12'd1) >> 1);
    end

    st_next.clk_out = div_out;
    st_next.clk_out[mcs_pkg::CH_PUMP] = div_out[mcs_pkg::CH_PUMP]
                                        & pump_enable_bit;
    if (!chopper_select_field[1]) begin
      st_next.clk_out[mcs_pkg::CH_CHOP] = chopper_select_field[0];
    end

    // data phase of a write; both registers steer the dividers above
    if (st_reg.wr_pend) begin
      case (st_reg.wr_idx)
        mcs_pkg::MCS_IDX_MAIN:
          st_next.main_reg = hwdata[7:0] & mcs_pkg::MCS_MAIN_MASK;
        mcs_pkg::MCS_IDX_PERIPH:
          st_next.periph_reg = hwdata[7:0] & mcs_pkg::MCS_PERIPH_MASK;
        default: ;
      endcase
    end

    // address phase; read data uses the post-write value
    if (hsel && htrans[1] && hready) begin
      st_next.wr_pend = hwrite;
      st_next.wr_idx  = haddr[9:2];
      case (haddr[9:2])
        mcs_pkg::MCS_IDX_MAIN:   rd = {24'h00_0000, st_next.main_reg};
        mcs_pkg::MCS_IDX_PERIPH: rd = {24'h00_0000, st_next.periph_reg};
        mcs_pkg::MCS_IDX_STATUS: rd = {26'h000_0000, st_reg.int_en,
                                       st_reg.ext_en, st_reg.main_clk,
                                       st_reg.sec_clk, st_reg.clk_out[1:0]};
        default:                 rd = 32'h0000_0000;
      endcase
      if (!hwrite) begin
        st_next.rdata = rd;
      end
    end else if (hready) begin
      st_next.wr_pend = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_reg            <= '0;
      st_reg.main_reg   <= mcs_pkg::MCS_MAIN_RST;
      st_reg.periph_reg <= mcs_pkg::MCS_PERIPH_RST;
      st_reg.ready      <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  assign hrdata                = st_reg.rdata;
  assign hreadyout             = st_reg.ready;
  assign hresp                 = 1'b0;
  assign int_osc_en            = st_reg.int_en;
  assign ext_osc_en            = st_reg.ext_en;
  assign main_clock            = st_reg.main_clk;
  assign secondary_clock       = st_reg.sec_clk;
  assign cpu_cycle_clk         = st_reg.clk_out[mcs_pkg::CH_CPU];
  assign converter_sample_rate = st_reg.clk_out[mcs_pkg::CH_ADC];
  assign beeper_clk            = st_reg.clk_out[mcs_pkg::CH_BEEP];
  assign pump_clk              = st_reg.clk_out[mcs_pkg::CH_PUMP];
  assign chopper_ctrl          = st_reg.clk_out[mcs_pkg::CH_CHOP];
  assign timer_display_clock   = st_reg.clk_out[mcs_pkg::CH_TMR];

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_sleep_osc_off: assert property (
      sleep_req |=> !int_osc_en && !ext_osc_en)
    else $error("oscillator left running in sleep");
  a_osc_ext_only: assert property (
      !sleep_req && osc_ctrl == 2'b10 |=> !int_osc_en && ext_osc_en)
    else $error("wrong oscillator enables for control 10");
  a_osc_both_on: assert property (
      !sleep_req && osc_ctrl == 2'b00 |=> int_osc_en && ext_osc_en)
    else $error("wrong oscillator enables for control 00");
  a_pump_gated: assert property (
      !pump_enable_bit |=> !pump_clk)
    else $error("pump clock runs while disabled");
  // one cycle only: a new field value may land right after this one
  a_chop_const: assert property (
      chopper_select_field == 2'b01 |=> chopper_ctrl)
    else $error("chopper not held high");
  a_chop_low: assert property (
      chopper_select_field == 2'b00 |=> !chopper_ctrl)
    else $error("chopper not held low");
  a_div_restart: assert property (
      st_reg.key[mcs_pkg::CH_ADC]
        != {src[mcs_pkg::CH_ADC], per[mcs_pkg::CH_ADC]}
      |=> st_reg.cnt[mcs_pkg::CH_ADC] == '0)
    else $error("converter divider not restarted");
  a_adc_period: assert property (
      prescale_bit && $stable(prescale_bit)
      |-> st_reg.cnt[mcs_pkg::CH_ADC] < mcs_pkg::MCS_P_ADC_1)
    else $error("converter divider overran");
  a_main_ick: assert property (
      !source_select_bit && ick_edge |-> main_ht)
    else $error("internal edge lost from main clock");
  a_sec_quarter: assert property (
      prescale_bit && main_ht && st_reg.sec_cnt != 2'd3 |-> !sec_ht)
    else $error("secondary clock not divided by four");
  a_write_main: assert property (
      st_reg.wr_pend && hready && st_reg.wr_idx == mcs_pkg::MCS_IDX_MAIN
      |=> st_reg.main_reg == ($past(hwdata[7:0]) & mcs_pkg::MCS_MAIN_MASK))
    else $error("main control write lost");
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("slave stalled or errored");

  c_sleep: cover property (!sleep_req ##1 sleep_req ##1 !int_osc_en);
  c_pump_run: cover property (pump_enable_bit ##1 $rose(pump_clk));
  c_beep_ext: cover property (beep_sel_bit && source_select_bit
                              ##1 $rose(beeper_clk));
  c_cpu_fast: cover property (cpu_speed_bit ##1 $rose(cpu_cycle_clk));

endmodule // mcs_clock_system

/* mcs_osc_model.sv */
// behavioural model of the two oscillators behind the clock pins
`timescale 1ns/1ps
module mcs_osc_model #(
  parameter real INT_HALF_NS = 500.0,
  parameter real EXT_HALF_NS = 15258.789
) (
  input  wire logic int_en,
  input  wire logic ext_en,
  output logic      int_clk,
  output logic      ext_clk
);
  ////////////////////////////////////////////////////////////////////////////
  // a stopped oscillator holds its pin low; small offset keeps pin edges
  // away from hclk edges so the sync delay is the same every time
  initial begin
    int_clk = 1'b0;
    #1.3;
    forever begin
      #(INT_HALF_NS);
      int_clk = int_en ? ~int_clk : 1'b0;
    end
  end

  initial begin
    ext_clk = 1'b0;
    #1.7;
    forever begin
      #(EXT_HALF_NS);
      ext_clk = ext_en ? ~ext_clk : 1'b0;
    end
  end
endmodule // mcs_osc_model

/* mcs_clock_system_tb.sv */
// self-checking bench for the mcu clock system
`timescale 1ns/1ps
module mcs_clock_system_tb;
  // oscillator half periods in hclk cycles, shortened to keep the run brief
  localparam int IH    = 3;
  localparam int EH    = 5;
  localparam int LIMIT = 95000;
  localparam logic [7:0] MI = mcs_pkg::MCS_IDX_MAIN;
  localparam logic [7:0] PI = mcs_pkg::MCS_IDX_PERIPH;

  logic        hclk, hresetn, hsel, hwrite, sleep_req;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic        hreadyout, hresp, int_osc_en, ext_osc_en, int_osc, ext_osc;
  wire  [7:0]  outs;
  int          miscompares, check_count, cyc;

  mcs_clock_system dut_u (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .internal_osc_clock(int_osc),
    .external_osc_clock(ext_osc), .sleep_req(sleep_req),
    .int_osc_en(int_osc_en), .ext_osc_en(ext_osc_en),
    .main_clock(outs[0]), .secondary_clock(outs[1]),
    .cpu_cycle_clk(outs[2]), .converter_sample_rate(outs[3]),
    .beeper_clk(outs[4]), .pump_clk(outs[5]), .chopper_ctrl(outs[6]),
    .timer_display_clock(outs[7])
  );

  mcs_osc_model #(.INT_HALF_NS(IH * 5.0), .EXT_HALF_NS(EH * 5.0)) osc_u (
    .int_en(int_osc_en), .ext_en(ext_osc_en),
    .int_clk(int_osc), .ext_clk(ext_osc)
  );

  initial hclk = 1'b0;
  always #2.5 hclk = ~hclk;

  ////////////////////////////////////////////////////////////////////////////
  task automatic results;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  always @(posedge hclk) begin
    cyc = cyc + 1;
    if (cyc == LIMIT) begin
      miscompares++;
      $display("BAD run length expected %0d seen %0d", LIMIT - 1, cyc);
      results();
    end
  end

  task automatic check(input string w, input logic [31:0] e,
                       input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", w, e, g);
    end
  endtask

  // one single transfer: address phase held until hready, then data phase
  task automatic bus(input logic wr, input logic [7:0] idx,
                     input logic [31:0] wd);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= {22'h0, idx, 2'b00};
    htrans <= 2'b10;
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wr ? wd : 32'h0000_0000;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic rdchk(input logic [7:0] idx, input logic [31:0] e);
    bus(1'b0, idx, 32'h0000_0000);
    check($sformatf("register %h", idx), e, rd);
    check("response", 1'b0, hresp);
    check("ready", 1'b1, hreadyout);
  endtask

  // cycles between the second and third rising edge of one output
  task automatic period(input int idx, input int exp);
    int  n, e, t0;
    logic p;
    n = 0;
    e = 0;
    t0 = 0;
    p = outs[idx];
    while (e < 3 && n < 30000) begin
      @(posedge hclk);
      n++;
      if (outs[idx] === 1'b1 && p === 1'b0) begin
        e++;
        if (e == 2) t0 = n;
      end
      p = outs[idx];
    end
    check($sformatf("period of output %0d", idx), exp, n - t0);
  endtask

  task automatic run(input logic [7:0] m, input logic [7:0] p, input int idx,
                     input int exp);
    bus(1'b1, MI, {24'h0, m});
    bus(1'b1, PI, {24'h0, p});
    repeat (4) @(posedge hclk);
    period(idx, exp);
  endtask

  // output must hold the given level for 60 cycles
  task automatic still(input int idx, input logic lvl);
    int t;
    t = 0;
    repeat (60) begin
      @(posedge hclk);
      if (outs[idx] !== lvl) t++;
    end
    check($sformatf("steady output %0d", idx), 0, t);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    hresetn = 1'b0; hsel = 1'b0; haddr = 32'h0000_0000; htrans = 2'b00;
    hwrite = 1'b0; hsize = 3'b010; hwdata = 32'h0000_0000;
    sleep_req = 1'b0; miscompares = 0; check_count = 0; cyc = 0;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    rdchk(MI, 32'h0000_0000);
    rdchk(PI, 32'h0000_0000);
    bus(1'b1, 8'h20, 32'hFFFF_FFFF);
    rdchk(8'h20, 32'h0000_0000);
    bus(1'b1, MI, 32'hFFFF_FF3E);
    rdchk(MI, 32'h0000_002E);
    bus(1'b1, PI, 32'hFFFF_FFFF);
    rdchk(PI, 32'h0000_004F);
    $display("test registers done");
    for (int s = 0; s < 2; s++) begin
      for (int c = 0; c < 4; c++) begin
        sleep_req <= s[0];
        bus(1'b1, MI, {24'h0, c[1:0], 6'h00});
        repeat (3) @(posedge hclk);
        check("int enable", s == 0 && c != 2, int_osc_en);
        check("ext enable", s == 0 && !c[0], ext_osc_en);
        bus(1'b0, mcs_pkg::MCS_IDX_STATUS, 32'h0000_0000);
        check("status int", s == 0 && c != 2, rd[5]);
        check("status ext", s == 0 && !c[0], rd[4]);
      end
    end
    still(0, outs[0]);
    sleep_req <= 1'b0;
    $display("test oscillator control done");
    run(8'h00, 8'h40, 0, 2 * IH);
    run(8'h00, 8'h40, 1, 2 * IH);
    run(8'h00, 8'h40, 2, 13 * IH);
    run(8'h00, 8'h40, 3, 50 * IH);
    run(8'h00, 8'h40, 4, 500 * IH);
    run(8'h00, 8'h40, 5, 400 * IH);
    run(8'h00, 8'h40, 7, 2000 * IH);
    run(8'h00, 8'h41, 5, 200 * IH);
    run(8'h00, 8'h4A, 4, 750 * IH);
    run(8'h00, 8'h4A, 6, 1000 * IH);
    run(8'h00, 8'h0C, 6, 2000 * IH);
    still(5, 1'b0);
    run(8'h02, 8'h40, 1, 8 * IH);
    run(8'h02, 8'h40, 2, 25 * IH);
    run(8'h02, 8'h40, 3, 100 * IH);
    // no conversion runs here, so the fast cpu setting is harmless
    run(8'h04, 8'h40, 2, 4 * IH);
    run(8'h06, 8'h40, 2, 8 * IH);
    $display("test internal source done");
    // external oscillator has run since the first internal source run, so it is stable
    run(8'h01, 8'h43, 0, 2 * EH);
    run(8'h01, 8'h43, 4, 16 * EH);
    run(8'h01, 8'h43, 5, 64 * EH);
    run(8'h09, 8'h40, 0, 4 * EH);
    run(8'h20, 8'h40, 7, 64 * EH);
    bus(1'b1, PI, 32'h0000_0004);
    repeat (3) @(posedge hclk);
    still(6, 1'b1);
    bus(1'b1, PI, 32'h0000_0000);
    repeat (3) @(posedge hclk);
    still(6, 1'b0);
    $display("test external source and chopper done");
    results();
  end
endmodule // mcs_clock_system_tb
